// *** rtl/byte_fifo.sv ***
`timescale 1ns/10ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic mclk,
  input wire logic sys_rst,
  byte_stream_if.sink wr,
  byte_stream_if.source rd
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("byte_fifo depth must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wp_q;
  logic [AW:0] rp_q;
  logic full;
  logic empty;
  assign empty = wp_q == rp_q;
  assign full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
  assign wr.ready = !full;
  assign rd.valid = !empty;
  assign rd.data = mem[rp_q[AW-1:0]];

  always_ff @(posedge mclk) begin
    if (wr.valid && !full) begin
      mem[wp_q[AW-1:0]] <= wr.data;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (wr.valid && !full) wp_q <= wp_q + 1'b1;
      if (rd.ready && !empty) rp_q <= rp_q + 1'b1;
    end
  end
endmodule

// *** rtl/byte_stream_if.sv ***
`timescale 1ns/10ps
interface byte_stream_if #(parameter int WIDTH = 8);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport source(output valid, output data, input ready);
  modport sink(input valid, input data, output ready);
endinterface

// *** rtl/polar_pkg.sv ***
package polar_pkg;
  // =====================================================
  // Timing
  localparam int CLK_HZ = 50_000_000;
  localparam int BAUD_RATE = 9600;
  localparam int BAUD_DIV_CYC = CLK_HZ / BAUD_RATE;
  localparam int SHUTTER_PHASE_MS = 50;
  localparam int SHUTTER_PHASE_CYC = (CLK_HZ / 1000) * SHUTTER_PHASE_MS;
  localparam int SHUTTER_TEST_TOGGLES = 20;
  localparam int CHOP_SLOT_HZ = 200;
  localparam int CHOP_TIMEOUT_CYC = 2 * (CLK_HZ / CHOP_SLOT_HZ);
  // =====================================================
  // Geometry
  localparam int COUNT_W = 24;
  localparam int DETECTORS = 3;
  localparam int CHANNELS = 2 * DETECTORS;
  localparam int READ_BYTES = 18;
  localparam int STEP_MILLIDEG = 1800;
  localparam int STEPS_PER_REV = 360_000 / STEP_MILLIDEG;
  localparam int TX_FIFO_DEPTH = 16;
  localparam logic [15:0] INTEG_RESET = 16'h0001;
  // =====================================================
  // Command codes and reply characters
  localparam logic [7:0] CMD_ECHO_SAME = 8'h11;
  localparam logic [7:0] CMD_ECHO_NEXT = 8'h12;
  localparam logic [7:0] CMD_PLATE_TEST = 8'h21;
  localparam logic [7:0] CMD_CHOP_TEST = 8'h22;
  localparam logic [7:0] CMD_SHUT_TEST = 8'h24;
  localparam logic [7:0] CMD_READ = 8'h60;
  localparam logic [7:0] CMD_SET_RPS = 8'h72;
  localparam logic [7:0] CMD_STATUS = 8'h81;
  localparam logic [7:0] CMD_SHUT_OPEN = 8'ha1;
  localparam logic [7:0] CMD_SHUT_CLOSE = 8'ha2;
  localparam logic [7:0] CMD_SET_INTEG = 8'hd0;
  localparam logic [3:0] GRP_CLEAR = 4'h3;
  localparam logic [3:0] GRP_START = 4'h4;
  localparam logic [3:0] GRP_STOP = 4'h5;
  localparam logic [7:0] ASCII_OK = 8'h4f;
  localparam logic [7:0] ASCII_NOT = 8'h4e;
  localparam logic [7:0] ASCII_PROGRESS = 8'h50;
  localparam logic [7:0] ASCII_COMPLETE = 8'h43;
  localparam logic [7:0] RPS_RESET = 8'h64;

  typedef enum {ST_IDLE, ST_ARG1, ST_ARG2, ST_SEND, ST_SHUT} cmd_state_t;
  typedef enum {SG_WAIT_ORD, SG_ORD, SG_WAIT_EXT, SG_EXT} steer_t;
endpackage

// *** rtl/polarimeter_serial_command_controller.sv ***
`timescale 1ns/10ps
module polarimeter_serial_command_controller #(
  parameter int BAUD_DIV = polar_pkg::BAUD_DIV_CYC,
  parameter int SHUT_PHASE = polar_pkg::SHUTTER_PHASE_CYC,
  parameter int CHOP_TIMEOUT = polar_pkg::CHOP_TIMEOUT_CYC
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic rxd_pin,
  output logic txd,
  input wire logic [polar_pkg::DETECTORS-1:0] photon_detector_pulse,
  input wire logic slot_ord_sensor,
  input wire logic slot_ext_sensor,
  input wire logic plate_rotation_ok,
  input wire logic plate_step_pulse,
  output logic shutter_open,
  output logic [7:0] chopper_rps,
  output logic [7:0] plate_position,
  output logic integration_running
);
  import polar_pkg::*;

  if (SHUT_PHASE < 1 || CHOP_TIMEOUT < 2 || CHOP_TIMEOUT > 16777215) begin : g_bad_timing
    $error("timing parameter out of range");
  end

  byte_stream_if rx_if();
  byte_stream_if cmd_tx_if();
  byte_stream_if line_tx_if();

  serial_port #(.DIV(BAUD_DIV)) u_port (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .rxd_pin(rxd_pin),
    .txd(txd),
    .rx(rx_if.source),
    .tx(line_tx_if.sink)
  );

  byte_fifo #(.WIDTH(8), .DEPTH(TX_FIFO_DEPTH)) u_tx_fifo (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .wr(cmd_tx_if.sink),
    .rd(line_tx_if.source)
  );

  // The receiver cannot be stalled; bytes arriving while a command runs are lost.
  assign rx_if.ready = 1'b1;

  // =====================================================
  // Pin synchronisers and edge detection
  logic [2:0] ord_s_q;
  logic [2:0] ext_s_q;
  logic [2:0] plate_ok_s_q;
  logic [2:0] step_s_q;
  logic [2:0] det_s_q [DETECTORS];
  logic ord_rise;
  logic ord_fall;
  logic ext_rise;
  logic ext_fall;
  logic [DETECTORS-1:0] det_rise;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ord_s_q <= '0;
      ext_s_q <= '0;
      plate_ok_s_q <= '0;
      step_s_q <= '0;
    end else begin
      ord_s_q <= {ord_s_q[1:0], slot_ord_sensor};
      ext_s_q <= {ext_s_q[1:0], slot_ext_sensor};
      plate_ok_s_q <= {plate_ok_s_q[1:0], plate_rotation_ok};
      step_s_q <= {step_s_q[1:0], plate_step_pulse};
    end
  end

  assign ord_rise = ord_s_q[1] && !ord_s_q[2];
  assign ord_fall = !ord_s_q[1] && ord_s_q[2];
  assign ext_rise = ext_s_q[1] && !ext_s_q[2];
  assign ext_fall = !ext_s_q[1] && ext_s_q[2];

  // =====================================================
  // Command engine
  cmd_state_t state_q;
  logic [7:0] cmd_q;
  logic [7:0] reply_q;
  logic read_mode_q;
  logic [4:0] send_left_q;
  logic [2:0] word_q;
  logic [1:0] lane_q;
  logic [15:0] integ_num_q;
  logic [7:0] integ_hi_q;
  logic manual_open_q;
  logic [2:0] clr_mask_q;
  logic [2:0] start_mask_q;
  logic [2:0] stop_mask_q;
  logic [31:0] shut_cnt_q;
  logic [4:0] shut_toggles_q;
  logic shut_level_q;
  logic gate_q;
  logic spinning;
  logic [COUNT_W-1:0] cnt_q [CHANNELS];
  logic [COUNT_W-1:0] snap_q [CHANNELS];
  logic [7:0] rx_byte;

  assign rx_byte = rx_if.data;

  // Low nibble picks detectors 1, 2, 3 by bits 0..2; bit 3 picks all three.
  function automatic logic [2:0] detector_mask(input logic [7:0] code);
    detector_mask = code[3] ? 3'b111 : code[2:0];
  endfunction

  function automatic logic [7:0] pick_lane(input logic [COUNT_W-1:0] w, input logic [1:0] lane);
    case (lane)
      2'd0: pick_lane = w[23:16];
      2'd1: pick_lane = w[15:8];
      default: pick_lane = w[7:0];
    endcase
  endfunction

  assign cmd_tx_if.valid = state_q == ST_SEND;
  assign cmd_tx_if.data = read_mode_q ? pick_lane(snap_q[word_q], lane_q) : reply_q;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      cmd_q <= '0;
      reply_q <= '0;
      read_mode_q <= 1'b0;
      send_left_q <= '0;
      word_q <= '0;
      lane_q <= '0;
      integ_num_q <= INTEG_RESET;
      integ_hi_q <= '0;
      chopper_rps <= RPS_RESET;
      manual_open_q <= 1'b0;
      clr_mask_q <= '0;
      start_mask_q <= '0;
      stop_mask_q <= '0;
      shut_cnt_q <= '0;
      shut_toggles_q <= '0;
      shut_level_q <= 1'b0;
    end else begin
      clr_mask_q <= '0;
      start_mask_q <= '0;
      stop_mask_q <= '0;
      case (state_q)
        ST_IDLE: begin
          if (rx_if.valid) begin
            cmd_q <= rx_byte;
            read_mode_q <= 1'b0;
            send_left_q <= 5'd1;
            case (rx_byte)
              CMD_ECHO_SAME, CMD_ECHO_NEXT, CMD_SET_RPS, CMD_SET_INTEG: state_q <= ST_ARG1;
              CMD_PLATE_TEST: begin
                reply_q <= plate_ok_s_q[1] ? ASCII_OK : ASCII_NOT;
                state_q <= ST_SEND;
              end
              CMD_CHOP_TEST: begin
                reply_q <= spinning ? ASCII_OK : ASCII_NOT;
                state_q <= ST_SEND;
              end
              CMD_SHUT_TEST: begin
                shut_cnt_q <= '0;
                shut_toggles_q <= '0;
                shut_level_q <= 1'b1;
                state_q <= ST_SHUT;
              end
              CMD_SHUT_OPEN: manual_open_q <= 1'b1;
              CMD_SHUT_CLOSE: manual_open_q <= 1'b0;
              CMD_STATUS: begin
                reply_q <= gate_q ? ASCII_PROGRESS : ASCII_COMPLETE;
                state_q <= ST_SEND;
              end
              CMD_READ: begin
                snap_q <= cnt_q;
                read_mode_q <= 1'b1;
                send_left_q <= 5'(READ_BYTES);
                word_q <= '0;
                lane_q <= '0;
                state_q <= ST_SEND;
              end
              default: begin
                if (rx_byte[7:4] == GRP_CLEAR) clr_mask_q <= detector_mask(rx_byte);
                if (rx_byte[7:4] == GRP_START) start_mask_q <= detector_mask(rx_byte);
                if (rx_byte[7:4] == GRP_STOP) stop_mask_q <= detector_mask(rx_byte);
              end
            endcase
          end
        end
        ST_ARG1: begin
          if (rx_if.valid) begin
            state_q <= ST_SEND;
            case (cmd_q)
              CMD_ECHO_SAME: reply_q <= rx_byte;
              CMD_ECHO_NEXT: reply_q <= rx_byte + 8'h01;
              CMD_SET_RPS: begin
                chopper_rps <= rx_byte;
                state_q <= ST_IDLE;
              end
              default: begin
                integ_hi_q <= rx_byte;
                state_q <= ST_ARG2;
              end
            endcase
          end
        end
        ST_ARG2: begin
          if (rx_if.valid) begin
            integ_num_q <= {integ_hi_q, rx_byte};
            state_q <= ST_IDLE;
          end
        end
        ST_SEND: begin
          if (cmd_tx_if.ready) begin
            send_left_q <= send_left_q - 1'b1;
            if (lane_q == 2'd2) begin
              lane_q <= '0;
              word_q <= word_q + 1'b1;
            end else begin
              lane_q <= lane_q + 1'b1;
            end
            if (send_left_q == 5'd1) state_q <= ST_IDLE;
          end
        end
        ST_SHUT: begin
          if (shut_cnt_q == 32'(SHUT_PHASE - 1)) begin
            shut_cnt_q <= '0;
            shut_level_q <= !shut_level_q;
            shut_toggles_q <= shut_toggles_q + 1'b1;
            if (shut_toggles_q == 5'(SHUTTER_TEST_TOGGLES - 1)) begin
              reply_q <= ASCII_OK;
              state_q <= ST_SEND;
            end
          end else begin
            shut_cnt_q <= shut_cnt_q + 1'b1;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // =====================================================
  // Shutter drive
  always_ff @(posedge mclk) begin
    if (sys_rst) shutter_open <= 1'b0;
    else if (state_q == ST_SHUT) shutter_open <= shut_level_q;
    else shutter_open <= manual_open_q || gate_q;
  end

  // =====================================================
  // Master gate, integration count and steering
  steer_t steer_q;
  logic [2:0] run_q;
  logic [15:0] integ_left_q;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      run_q <= '0;
      gate_q <= 1'b0;
      steer_q <= SG_WAIT_ORD;
      integ_left_q <= '0;
    end else begin
      run_q <= (run_q | start_mask_q) & ~stop_mask_q;
      if (start_mask_q != 0 && !gate_q && integ_num_q != 0) begin
        gate_q <= 1'b1;
        integ_left_q <= integ_num_q;
        steer_q <= SG_WAIT_ORD;
      end else if (stop_mask_q == 3'b111 || !gate_q) begin
        gate_q <= 1'b0;
        steer_q <= SG_WAIT_ORD;
      end else begin
        case (steer_q)
          SG_WAIT_ORD: if (ord_rise) steer_q <= SG_ORD;
          SG_ORD: if (ord_fall) steer_q <= SG_WAIT_EXT;
          SG_WAIT_EXT: begin
            if (ext_rise) begin
              steer_q <= SG_EXT;
              integ_left_q <= integ_left_q - 1'b1;
            end
          end
          SG_EXT: begin
            if (ext_fall) begin
              steer_q <= SG_WAIT_ORD;
              if (integ_left_q == 0) gate_q <= 1'b0;
            end
          end
          default: steer_q <= SG_WAIT_ORD;
        endcase
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) integration_running <= 1'b0;
    else integration_running <= gate_q;
  end

  // =====================================================
  // Detector counters, one ordinary and one extraordinary per detector
  for (genvar d = 0; d < DETECTORS; d++) begin : g_det
    always_ff @(posedge mclk) begin
      if (sys_rst) det_s_q[d] <= '0;
      else det_s_q[d] <= {det_s_q[d][1:0], photon_detector_pulse[d]};
    end
    assign det_rise[d] = det_s_q[d][1] && !det_s_q[d][2];

    always_ff @(posedge mclk) begin
      if (sys_rst || clr_mask_q[d]) begin
        cnt_q[2*d] <= '0;
        cnt_q[2*d+1] <= '0;
      end else if (gate_q && run_q[d] && det_rise[d]) begin
        if (steer_q == SG_ORD) cnt_q[2*d] <= cnt_q[2*d] + 1'b1;
        if (steer_q == SG_EXT) cnt_q[2*d+1] <= cnt_q[2*d+1] + 1'b1;
      end
    end
  end

  // =====================================================
  // Chopper watchdog: slots alternate at twice the wheel rate, so two
  // alternation periods without an ordinary edge means the wheel has stopped.
  logic [23:0] chop_cnt_q;
  assign spinning = chop_cnt_q < 24'(CHOP_TIMEOUT);

  always_ff @(posedge mclk) begin
    if (sys_rst) chop_cnt_q <= 24'(CHOP_TIMEOUT);
    else if (ord_rise) chop_cnt_q <= '0;
    else if (spinning) chop_cnt_q <= chop_cnt_q + 1'b1;
  end

  // =====================================================
  // Plate position in whole steps, wrapping after one turn
  always_ff @(posedge mclk) begin
    if (sys_rst) plate_position <= '0;
    else if (step_s_q[1] && !step_s_q[2]) begin
      if (plate_position == 8'(STEPS_PER_REV - 1)) plate_position <= '0;
      else plate_position <= plate_position + 1'b1;
    end
  end
endmodule

// *** rtl/serial_port.sv ***
`timescale 1ns/10ps
module serial_port #(
  parameter int DIV = 5208
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic rxd_pin,
  output logic txd,
  byte_stream_if.source rx,
  byte_stream_if.sink tx
);
  if (DIV < 4 || DIV > 65535) begin : g_bad_div
    $error("serial_port divider out of range");
  end
  // =====================================================
  // Receiver: 8N1, sampled at the middle of each bit.
  logic [1:0] rx_s_q;
  logic [15:0] rx_cnt_q;
  logic [3:0] rx_bit_q;
  logic [8:0] rx_sh_q;
  logic rx_busy_q;
  logic rx_valid_q;
  assign rx.valid = rx_valid_q;
  assign rx.data = rx_sh_q[7:0];

  always_ff @(posedge mclk) begin
    if (sys_rst) rx_s_q <= 2'b11;
    else rx_s_q <= {rx_s_q[0], rxd_pin};
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rx_busy_q <= 1'b0;
      rx_cnt_q <= '0;
      rx_bit_q <= '0;
      rx_sh_q <= '0;
      rx_valid_q <= 1'b0;
    end else begin
      rx_valid_q <= 1'b0;
      if (!rx_busy_q) begin
        if (!rx_s_q[1]) begin
          rx_busy_q <= 1'b1;
          rx_cnt_q <= 16'(DIV / 2);
          rx_bit_q <= '0;
        end
      end else if (rx_cnt_q != 0) begin
        rx_cnt_q <= rx_cnt_q - 1'b1;
      end else begin
        rx_cnt_q <= 16'(DIV - 1);
        rx_bit_q <= rx_bit_q + 1'b1;
        if (rx_bit_q == 0 && rx_s_q[1]) begin
          rx_busy_q <= 1'b0;
        end else if (rx_bit_q != 0) begin
          rx_sh_q <= {rx_s_q[1], rx_sh_q[8:1]};
        end
        if (rx_bit_q == 4'd9) begin
          rx_busy_q <= 1'b0;
          // A byte whose stop bit is low is a framing error and is dropped.
          rx_valid_q <= rx_s_q[1];
        end
      end
    end
  end
  // =====================================================
  // Transmitter: start, eight data bits LSB first, one stop bit.
  logic [9:0] tx_sh_q;
  logic [15:0] tx_cnt_q;
  logic [3:0] tx_left_q;
  // Ready also waits out the stop bit, or a byte popped from the FIFO during it would be dropped unsent.
  assign tx.ready = (tx_left_q == 0) && (tx_cnt_q == 0);

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tx_sh_q <= '1;
      tx_cnt_q <= '0;
      tx_left_q <= '0;
      txd <= 1'b1;
    end else if (tx_cnt_q != 0) begin
      tx_cnt_q <= tx_cnt_q - 1'b1;
    end else if (tx_left_q == 0) begin
      txd <= 1'b1;
      if (tx.valid) begin
        tx_sh_q <= {1'b1, tx.data, 1'b0};
        tx_left_q <= 4'd10;
        tx_cnt_q <= '0;
      end
    end else begin
      txd <= tx_sh_q[0];
      tx_sh_q <= {1'b1, tx_sh_q[9:1]};
      tx_left_q <= tx_left_q - 1'b1;
      tx_cnt_q <= 16'(DIV - 1);
    end
  end
endmodule

// *** test/host_serial_model.sv ***
`timescale 1ns/10ps
module host_serial_model #(
  parameter int DIV = 16
) (
  input wire logic mclk,
  input wire logic line_in,
  output logic line_out
);
  // ====================
  // Host serial port, 8N1, LSB first, idle high, no handshake lines.
  initial line_out = 1'b1;
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge mclk);
      line_out = f[i];
      repeat (DIV - 1) @(negedge mclk);
    end
  endtask
  // Sampling on the falling edge keeps clear of the transmitter flop.
  task automatic recv_byte(input int limit, output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    b = 8'h00;
    ok = 1'b0;
    while (line_in !== 1'b0 && n < limit) begin
      @(negedge mclk);
      n++;
    end
    if (line_in !== 1'b0) return;
    repeat (DIV / 2) @(negedge mclk);
    for (int i = 0; i < 8; i++) begin
      repeat (DIV) @(negedge mclk);
      b[i] = line_in;
    end
    repeat (DIV) @(negedge mclk);
    ok = (line_in === 1'b1);
  endtask
endmodule

// *** test/polar_checker.sv ***
`timescale 1ns/10ps
module polar_checker
  import polar_pkg::*;
#(
  parameter int BAUD_DIV = 16
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic rxd_pin,
  input wire logic txd,
  input wire logic plate_step_pulse,
  input wire logic shutter_open,
  input wire logic [7:0] chopper_rps,
  input wire logic [7:0] plate_position,
  input wire logic integration_running
);
  // ====================
  // Port relations.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_idle_after_rst: assert property ($fell(sys_rst) |-> txd && !shutter_open && !integration_running)
    else $error("outputs not idle after reset");
  a_rps_after_rst: assert property ($fell(sys_rst) |-> chopper_rps == RPS_RESET && plate_position == 8'h00)
    else $error("speed or plate position wrong after reset");
  a_plate_range: assert property (plate_position < STEPS_PER_REV)
    else $error("plate position beyond one turn");
  a_plate_wrap: assert property ($changed(plate_position) |->
    plate_position == (($past(plate_position) == 8'hc7) ? 8'h00 : $past(plate_position) + 8'h01))
    else $error("plate position did not step by one");
  a_plate_cause: assert property ($changed(plate_position) |-> $past(plate_step_pulse, 3))
    else $error("plate position moved without a step pulse");
  a_shut_gate: assert property (integration_running && $past(integration_running) |-> shutter_open)
    else $error("shutter closed while counting");
  a_start_len: assert property ($fell(txd) |-> (!txd[*8]) ##8 !txd)
    else $error("start bit shorter than one bit time");
  a_rps_cause: assert property ($changed(chopper_rps) |-> rxd_pin)
    else $error("speed changed without a received byte");
  a_gate_cause: assert property ($rose(integration_running) |-> rxd_pin)
    else $error("gate opened without a received byte");
endmodule

// *** test/polarimeter_serial_command_controller_tb.sv ***
`timescale 1ns/10ps
module polarimeter_serial_command_controller_tb;
  import polar_pkg::*;
  localparam int BDIV = 16;
  logic mclk, sys_rst, rxd, txd, step, slot_ord, slot_ext, rot_ok, shut, integ, chop_on;
  logic [2:0] pd;
  logic [7:0] rps, pos;
  logic [7:0] rx [18];
  int err_total, samples_checked, toggles, rx_n;
  polarimeter_serial_command_controller #(.BAUD_DIV(BDIV), .SHUT_PHASE(20), .CHOP_TIMEOUT(200)) i_dut (
    .mclk(mclk), .sys_rst(sys_rst), .rxd_pin(rxd), .txd(txd), .photon_detector_pulse(pd),
    .slot_ord_sensor(slot_ord), .slot_ext_sensor(slot_ext), .plate_rotation_ok(rot_ok),
    .plate_step_pulse(step), .shutter_open(shut), .chopper_rps(rps), .plate_position(pos),
    .integration_running(integ));
  host_serial_model #(.DIV(BDIV)) i_host (.mclk(mclk), .line_in(txd), .line_out(rxd));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(shut) toggles++;
  // ====================
  // Chopper: ordinary then extraordinary window, detector d gets d+1 or d+4 pulses.
  task automatic window(input logic ext);
    if (ext) slot_ext = 1'b1; else slot_ord = 1'b1;
    repeat (6) @(negedge mclk);
    for (int k = 0; k < 7; k++) begin
      for (int d = 0; d < 3; d++) pd[d] = (k < d + 1 + 3 * ext);
      repeat (3) @(negedge mclk);
      pd = 3'h0;
      repeat (3) @(negedge mclk);
    end
    repeat (12) @(negedge mclk);
    slot_ord = 1'b0;
    slot_ext = 1'b0;
    repeat (10) @(negedge mclk);
  endtask
  initial forever begin
    @(negedge mclk);
    if (chop_on) begin
      window(1'b0);
      window(1'b1);
    end
  end
  // ====================
  // Shared helpers.
  task automatic check(input string nm, input logic [23:0] exp, input logic [23:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cmd(input logic [7:0] c, input int na, input logic [15:0] a, input int nr);
    logic [7:0] b;
    logic ok;
    rx_n = 0;
    fork
      begin
        i_host.send_byte(c);
        if (na == 2) i_host.send_byte(a[15:8]);
        if (na > 0) i_host.send_byte(a[7:0]);
      end
      for (int r = 0; r < nr; r++) begin
        i_host.recv_byte(3000, b, ok);
        if (ok === 1'b1) begin
          rx[rx_n] = b;
          rx_n++;
        end
      end
    join
    repeat (BDIV) @(negedge mclk);
  endtask
  task automatic one(input logic [7:0] c, input int na, input logic [15:0] a, input logic [7:0] exp);
    cmd(c, na, a, 1);
    check("reply count", 24'h1, 24'(rx_n));
    check("reply byte", {16'h0, exp}, {16'h0, rx[0]});
  endtask
  task automatic none(input logic [7:0] c, input int na, input logic [15:0] a);
    cmd(c, na, a, 1);
    check("silence", 24'h0, 24'(rx_n));
  endtask
  task automatic pulse_plate(input int n);
    repeat (n) begin
      @(negedge mclk);
      step = 1'b1;
      repeat (10) @(negedge mclk);
      step = 1'b0;
      repeat (10) @(negedge mclk);
    end
  endtask
  // ====================
  // Scenarios.
  task automatic t_reset();
    check("txd", 24'h1, {23'h0, txd});
    check("shutter", 24'h0, {23'h0, shut});
    check("rps", {16'h0, RPS_RESET}, {16'h0, rps});
    check("gate", 24'h0, {23'h0, integ});
    $display("reset test done");
  endtask
  task automatic t_echo();
    one(CMD_ECHO_SAME, 1, 16'h0041, 8'h41);
    one(CMD_ECHO_NEXT, 1, 16'h0041, 8'h42);
    one(CMD_ECHO_NEXT, 1, 16'h00ff, 8'h00);
    none(8'h99, 0, 16'h0);
    $display("echo test done");
  endtask
  task automatic t_checks();
    one(CMD_PLATE_TEST, 0, 16'h0, ASCII_OK);
    rot_ok = 1'b0;
    one(CMD_PLATE_TEST, 0, 16'h0, ASCII_NOT);
    one(CMD_CHOP_TEST, 0, 16'h0, ASCII_NOT);
    chop_on = 1'b1;
    one(CMD_CHOP_TEST, 0, 16'h0, ASCII_OK);
    chop_on = 1'b0;
    $display("instrument test done");
  endtask
  task automatic t_shutter();
    none(CMD_SHUT_OPEN, 0, 16'h0);
    check("shutter open", 24'h1, {23'h0, shut});
    none(CMD_SHUT_CLOSE, 0, 16'h0);
    check("shutter closed", 24'h0, {23'h0, shut});
    toggles = 0;
    one(CMD_SHUT_TEST, 0, 16'h0, ASCII_OK);
    check("shutter toggles", 24'h14, 24'(toggles));
    check("shutter rest", 24'h0, {23'h0, shut});
    none(CMD_SET_RPS, 1, 16'h0037);
    check("rps", 24'h37, {16'h0, rps});
    $display("shutter test done");
  endtask
  task automatic t_plate();
    pulse_plate(199);
    check("plate", 24'hc7, {16'h0, pos});
    pulse_plate(2);
    check("plate wrap", 24'h1, {16'h0, pos});
    $display("plate test done");
  endtask
  task automatic t_acq();
    int n;
    repeat (400) @(negedge mclk);
    none({GRP_CLEAR, 4'h8}, 0, 16'h0);
    none(CMD_SET_INTEG, 2, 16'h0002);
    none({GRP_START, 4'h8}, 0, 16'h0);
    check("gate on", 24'h1, {23'h0, integ});
    one(CMD_STATUS, 0, 16'h0, ASCII_PROGRESS);
    chop_on = 1'b1;
    n = 0;
    while (integ !== 1'b0 && n < 5000) begin
      @(negedge mclk);
      n++;
    end
    chop_on = 1'b0;
    check("gate off", 24'h0, {23'h0, integ});
    one(CMD_STATUS, 0, 16'h0, ASCII_COMPLETE);
    cmd(CMD_READ, 0, 16'h0, 18);
    check("read bytes", 24'h12, 24'(rx_n));
    for (int d = 0; d < 3; d++) begin
      check("ord count", 24'(2 * (d + 1)), {rx[6*d], rx[6*d+1], rx[6*d+2]});
      check("ext count", 24'(2 * (d + 4)), {rx[6*d+3], rx[6*d+4], rx[6*d+5]});
    end
    none({GRP_CLEAR, 4'h2}, 0, 16'h0);
    cmd(CMD_READ, 0, 16'h0, 18);
    for (int d = 0; d < 3; d++) begin
      check("ord cleared", (d == 1) ? 24'h0 : 24'(2 * (d + 1)), {rx[6*d], rx[6*d+1], rx[6*d+2]});
      check("ext cleared", (d == 1) ? 24'h0 : 24'(2 * (d + 4)), {rx[6*d+3], rx[6*d+4], rx[6*d+5]});
    end
    none({GRP_START, 4'h8}, 0, 16'h0);
    check("gate restarted", 24'h1, {23'h0, integ});
    none({GRP_STOP, 4'h8}, 0, 16'h0);
    check("gate stopped", 24'h0, {23'h0, integ});
    $display("acquisition test done");
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    sys_rst = 1'b1;
    pd = 3'h0;
    slot_ord = 1'b0;
    slot_ext = 1'b0;
    rot_ok = 1'b1;
    step = 1'b0;
    chop_on = 1'b0;
    repeat (8) @(negedge mclk);
    sys_rst = 1'b0;
    @(negedge mclk);
    t_reset();
    t_echo();
    t_checks();
    t_shutter();
    t_plate();
    t_acq();
    end_sim();
  end
  initial begin
    repeat (95000) @(posedge mclk);
    err_total++;
    end_sim();
  end
endmodule
bind polarimeter_serial_command_controller polar_checker #(.BAUD_DIV(BAUD_DIV)) i_chk (
  .mclk(mclk), .sys_rst(sys_rst), .rxd_pin(rxd_pin), .txd(txd), .plate_step_pulse(plate_step_pulse),
  .shutter_open(shutter_open), .chopper_rps(chopper_rps), .plate_position(plate_position),
  .integration_running(integration_running));
